/* File: core/instr_decode.sv */
// Instruction decode front end with implementation special registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RL1] Every instruction is one aligned 32-bit word decoded in one format family.
// [RL2] Effective addresses use 32-bit unsigned sums; the carry out is dropped.
// [RL3] Computational instructions never write memory; only stores do.
// [RL4] Integer loads and stores move bytes, halves or words to 32 general registers.
// [RL5] Float loads and stores move words or doubles to 32 float registers.
// [RL6] Integer operands are byte, half or word; single is word, double is double.
// [RL7] All architectural instructions plus six optional ones are accepted.
// [RL8] The breakpoint address is compared with queued fetch addresses; a match traps.
// [RL9] User aliases give read-only access to monitor controls, counters, sampled address.
// [RL10] Four counters count events chosen by the monitor controls, which enable interrupts.
// [RL11] On the monitor condition the sampled address register captures a current address.
// [RL12] Reading the second implementation register returns the clock configuration pins.
// [RL13] The throttle register sets the fetch interval into the instruction buffer.
// [RL14] Thermal unit compares sensor with two or one threshold; third register enables.
// [RL15] Access permission follows the problem-state bit of the machine state register.
// [RL16] Illegal user special register access traps and changes nothing.
module instr_decode
  import idec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] reg_a_val,
  input wire logic [31:0] reg_b_val,
  input wire logic [31:0] spr_wr_data,
  input wire logic problem_state_bit,
  input wire logic [3:0] pll_cfg,
  input wire logic [6:0] thermal_sensor,
  input wire logic [31:0] perf_events,
  input wire logic [31:0] exec_addr,
  output logic dec_valid,
  output logic dec_illegal,
  output logic dec_privileged,
  output logic dec_mem_write,
  output logic dec_mem_read,
  output logic [1:0] dec_size,
  output logic [1:0] dec_file,
  output logic [4:0] dec_rt,
  output logic [31:0] dec_ea,
  output logic [31:0] spr_rd_data,
  output logic breakpoint_trap,
  output logic fetch_enable,
  output logic thermal_alert,
  output logic perf_interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction.
  logic [5:0] op;
  logic [9:0] xo;
  logic [4:0] xo5;
  logic [9:0] spr;
  logic [31:0] disp;
  logic is_d, is_x, is_mt, is_mf;

  assign op = instr_word[31:26]; // [RL1]
  assign xo = instr_word[10:1];
  assign xo5 = instr_word[5:1];
  assign spr = {instr_word[15:11], instr_word[20:16]};
  assign disp = {{16{instr_word[15]}}, instr_word[15:0]};
  assign is_x = (op == OP_EXT31);
  assign is_mt = is_x && xo == XO_MTSPR;
  assign is_mf = is_x && xo == XO_MFSPR;
  assign is_d = (op >= OP_LWZ) && (op <= OP_STFD);

  function automatic logic is_user_alias(input logic [9:0] n);
    is_user_alias = (n >= SPR_U_MON_A) && (n <= SPR_U_CNT4);
  endfunction : is_user_alias

  function automatic logic is_owned(input logic [9:0] n);
    is_owned = is_user_alias(n) || ((n >= SPR_MON_A) && (n <= SPR_CNT4)) ||
      n == SPR_THRMA || n == SPR_THRMB || n == SPR_THRMC || n == SPR_THROT ||
      n == SPR_IMPL0 || n == SPR_IMPL1 || n == SPR_BKPT;
  endfunction : is_owned

  ////////////////////////////////////////////////////////////////////////////
  // Decode.
  logic nxt_valid, nxt_illegal, nxt_priv, nxt_wr, nxt_rd;
  logic [1:0] nxt_size, nxt_file;
  logic [31:0] nxt_ea;
  logic spr_fault, spr_wr_ok;

  always_comb
  begin
    nxt_valid = instr_valid;
    nxt_illegal = 1'b0;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    nxt_size = SZ_WORD;
    nxt_file = FILE_NONE;
    nxt_ea = 32'(reg_a_val + disp); // [RL2]
    if (is_x)
    begin
      nxt_ea = 32'(reg_a_val + reg_b_val); // [RL2]
    end
    spr_fault = (is_mt || is_mf) && problem_state_bit && is_owned(spr) &&
      (is_mt || !is_user_alias(spr)); // [RL15] [RL16]
    nxt_priv = instr_valid && spr_fault; // [RL16]
    spr_wr_ok = instr_valid && is_mt && !spr_fault && !is_user_alias(spr); // [RL9]
    unique case (op)
      OP_LBZ: begin nxt_rd = 1'b1; nxt_size = SZ_BYTE; nxt_file = FILE_INT; end // [RL4]
      OP_LHZ, OP_LHA: begin nxt_rd = 1'b1; nxt_size = SZ_HALF; nxt_file = FILE_INT; end
      OP_LWZ: begin nxt_rd = 1'b1; nxt_file = FILE_INT; end
      OP_STB: begin nxt_wr = 1'b1; nxt_size = SZ_BYTE; nxt_file = FILE_INT; end
      OP_STH: begin nxt_wr = 1'b1; nxt_size = SZ_HALF; nxt_file = FILE_INT; end
      OP_STW: begin nxt_wr = 1'b1; nxt_file = FILE_INT; end
      OP_LFS: begin nxt_rd = 1'b1; nxt_file = FILE_FLT; end // [RL5] [RL6]
      OP_LFD: begin nxt_rd = 1'b1; nxt_size = SZ_DOUBLE; nxt_file = FILE_FLT; end
      OP_STFS: begin nxt_wr = 1'b1; nxt_file = FILE_FLT; end
      OP_STFD: begin nxt_wr = 1'b1; nxt_size = SZ_DOUBLE; nxt_file = FILE_FLT; end
      OP_EXT31:
      begin
        // Optional external control and integer-word float store.
        if (xo == XO_ECIWX)
        begin
          nxt_rd = 1'b1; // [RL7]
          nxt_file = FILE_INT;
        end
        else if (xo == XO_ECOWX || xo == XO_STFIWX)
        begin
          nxt_wr = 1'b1; // [RL7] [RL3]
          nxt_file = (xo == XO_STFIWX) ? FILE_FLT : FILE_INT;
        end
      end
      OP_EXT59:
      begin
        nxt_size = SZ_WORD; // [RL6]
        nxt_file = FILE_FLT;
      end
      OP_EXT63:
      begin
        nxt_size = SZ_DOUBLE;
        nxt_file = FILE_FLT;
        if (xo5 == XO_FSEL || xo5 == XO_FRES || xo5 == XO_FRSQRTE)
        begin
          nxt_size = (xo5 == XO_FRES) ? SZ_WORD : SZ_DOUBLE; // [RL7]
        end
      end
      default:
      begin
        // Remaining opcodes are register computations: no memory write.
        nxt_wr = 1'b0; // [RL3]
        nxt_illegal = instr_valid && (op == 6'h00 || op == 6'h01);
      end
    endcase
    nxt_illegal = nxt_illegal || (instr_valid && instr_addr[1:0] != 2'h0); // [RL1]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special registers.
  logic [31:0] bkpt_ff, throt_ff, thra_ff, thrb_ff, thrc_ff, mmca_ff, mmcb_ff, samp_ff, impl0_ff;
  logic [31:0] nxt_bkpt, nxt_throt, nxt_thra, nxt_thrb, nxt_thrc, nxt_mmca, nxt_mmcb, nxt_samp;
  logic [31:0] nxt_impl0, nxt_rdata;
  logic [7:0] thr_cnt_ff, nxt_thr_cnt;
  logic [12:0] sit_cnt_ff, nxt_sit_cnt;
  logic nxt_fetch, nxt_bp, nxt_alert, nxt_pmi, pmi_ff;
  logic [127:0] counts;
  logic ovf, cnt_load;
  logic [6:0] lim_a, lim_b;
  logic hit_a, hit_b;

  assign cnt_load = spr_wr_ok && ((spr >= SPR_CNT1 && spr <= SPR_CNT2) ||
    spr == SPR_CNT3 || spr == SPR_CNT4);

  perf_counters u_counters (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ctrl_a(mmca_ff),
    .ctrl_b(mmcb_ff),
    .event_vec(perf_events),
    .load_en(cnt_load),
    .load_idx((spr == SPR_CNT1) ? 2'h0 : (spr == SPR_CNT2) ? 2'h1 :
      (spr == SPR_CNT3) ? 2'h2 : 2'h3),
    .load_val(spr_wr_data),
    .counts(counts),
    .overflow(ovf)
  );

  assign lim_a = thra_ff[THR_LSB +: THR_W];
  assign lim_b = thrb_ff[THR_LSB +: THR_W];
  assign hit_a = thra_ff[THR_VALID_BIT] &&
    (thra_ff[THR_DIR_BIT] ? thermal_sensor > lim_a : thermal_sensor < lim_a);
  assign hit_b = thrb_ff[THR_VALID_BIT] &&
    (thrb_ff[THR_DIR_BIT] ? thermal_sensor > lim_b : thermal_sensor < lim_b);

  always_comb
  begin
    nxt_bkpt = bkpt_ff;
    nxt_throt = throt_ff;
    nxt_thra = thra_ff;
    nxt_thrb = thrb_ff;
    nxt_thrc = thrc_ff;
    nxt_mmca = mmca_ff;
    nxt_mmcb = mmcb_ff;
    nxt_impl0 = impl0_ff;
    nxt_samp = samp_ff;
    if (spr_wr_ok)
    begin
      unique case (spr)
        SPR_BKPT: nxt_bkpt = spr_wr_data;
        SPR_THROT: nxt_throt = spr_wr_data;
        SPR_THRMA: nxt_thra = spr_wr_data;
        SPR_THRMB: nxt_thrb = spr_wr_data;
        SPR_THRMC: nxt_thrc = spr_wr_data;
        SPR_MON_A: nxt_mmca = spr_wr_data;
        SPR_MON_B: nxt_mmcb = spr_wr_data;
        SPR_SAMP: nxt_samp = spr_wr_data;
        SPR_IMPL0: nxt_impl0 = spr_wr_data;
        default: nxt_bkpt = bkpt_ff;
      endcase
    end
    nxt_pmi = mmca_ff[MMCR_PMI_BIT] && ovf; // [RL10]
    if (nxt_pmi && !pmi_ff)
    begin
      nxt_samp = exec_addr; // [RL11]
    end
    // Throttle: fetch allowed one cycle in every interval plus one cycles when enabled.
    nxt_thr_cnt = thr_cnt_ff + 8'h01;
    nxt_fetch = 1'b1;
    if (throt_ff[THROT_EN_BIT])
    begin
      nxt_fetch = (thr_cnt_ff >= throt_ff[THROT_INT_LSB +: THROT_INT_W]); // [RL13]
      if (nxt_fetch)
      begin
        nxt_thr_cnt = 8'h00;
      end
    end
    // Sampled thermal comparison only on each sample interval.
    nxt_alert = thermal_alert;
    nxt_sit_cnt = sit_cnt_ff + 13'h0001;
    if (!thrc_ff[THRM_EN_BIT])
    begin
      nxt_alert = 1'b0;
      nxt_sit_cnt = 13'h0000;
    end
    else if (sit_cnt_ff >= thrc_ff[THRM_SIT_LSB +: THRM_SIT_W])
    begin
      nxt_alert = hit_a || hit_b; // [RL14]
      nxt_sit_cnt = 13'h0000;
    end
    nxt_bp = instr_valid && bkpt_ff[BKPT_EN_BIT] &&
      (instr_addr[31:2] == bkpt_ff[31:2]); // [RL8]
    nxt_rdata = RESET_WORD;
    if (is_mf && instr_valid && !spr_fault && is_owned(spr))
    begin
      unique case (spr)
        SPR_BKPT: nxt_rdata = bkpt_ff;
        SPR_THROT: nxt_rdata = throt_ff;
        SPR_THRMA: nxt_rdata = thra_ff;
        SPR_THRMB: nxt_rdata = thrb_ff;
        SPR_THRMC: nxt_rdata = thrc_ff;
        SPR_IMPL0: nxt_rdata = impl0_ff;
        SPR_IMPL1: nxt_rdata = {28'h000_0000, pll_cfg}; // [RL12]
        SPR_MON_A, SPR_U_MON_A: nxt_rdata = mmca_ff; // [RL9]
        SPR_MON_B, SPR_U_MON_B: nxt_rdata = mmcb_ff;
        SPR_CNT1, SPR_U_CNT1: nxt_rdata = counts[31:0];
        SPR_CNT2, SPR_U_CNT2: nxt_rdata = counts[63:32];
        SPR_CNT3, SPR_U_CNT3: nxt_rdata = counts[95:64];
        SPR_CNT4, SPR_U_CNT4: nxt_rdata = counts[127:96];
        SPR_SAMP, SPR_U_SAMP: nxt_rdata = samp_ff;
        default: nxt_rdata = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bkpt_ff <= RESET_WORD;
      throt_ff <= RESET_WORD;
      thra_ff <= RESET_WORD;
      thrb_ff <= RESET_WORD;
      thrc_ff <= RESET_WORD;
      mmca_ff <= RESET_WORD;
      mmcb_ff <= RESET_WORD;
      samp_ff <= RESET_WORD;
      impl0_ff <= RESET_WORD;
      thr_cnt_ff <= 8'h00;
      sit_cnt_ff <= 13'h0000;
      pmi_ff <= 1'b0;
      spr_rd_data <= RESET_WORD;
      breakpoint_trap <= 1'b0;
      fetch_enable <= 1'b1;
      thermal_alert <= 1'b0;
      perf_interrupt <= 1'b0;
      dec_valid <= 1'b0;
      dec_illegal <= 1'b0;
      dec_privileged <= 1'b0;
      dec_mem_write <= 1'b0;
      dec_mem_read <= 1'b0;
      dec_size <= SZ_WORD;
      dec_file <= FILE_NONE;
      dec_rt <= 5'h00;
      dec_ea <= RESET_WORD;
    end
    else
    begin
      bkpt_ff <= nxt_bkpt;
      throt_ff <= nxt_throt;
      thra_ff <= nxt_thra;
      thrb_ff <= nxt_thrb;
      thrc_ff <= nxt_thrc;
      mmca_ff <= nxt_mmca;
      mmcb_ff <= nxt_mmcb;
      samp_ff <= nxt_samp;
      impl0_ff <= nxt_impl0;
      thr_cnt_ff <= nxt_thr_cnt;
      sit_cnt_ff <= nxt_sit_cnt;
      pmi_ff <= nxt_pmi;
      spr_rd_data <= nxt_rdata;
      breakpoint_trap <= nxt_bp;
      fetch_enable <= nxt_fetch;
      thermal_alert <= nxt_alert;
      perf_interrupt <= nxt_pmi;
      dec_valid <= nxt_valid;
      dec_illegal <= nxt_illegal;
      dec_privileged <= nxt_priv;
      dec_mem_write <= nxt_wr && instr_valid;
      dec_mem_read <= nxt_rd && instr_valid;
      dec_size <= nxt_size;
      dec_file <= nxt_file;
      dec_rt <= instr_word[25:21];
      dec_ea <= nxt_ea;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_user_write_blocked: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL16]
    (instr_valid && is_mt && problem_state_bit && is_owned(spr))
    |=> dec_privileged && $stable(bkpt_ff))
    else $error("user write was not refused");
  a_breakpoint_match: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL8]
    (instr_valid && bkpt_ff[BKPT_EN_BIT] && instr_addr[31:2] == bkpt_ff[31:2]) |=> breakpoint_trap)
    else $error("breakpoint missed");
  a_pll_readback: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL12]
    (instr_valid && is_mf && !problem_state_bit && spr == SPR_IMPL1)
    |=> spr_rd_data == {28'h000_0000, $past(pll_cfg)})
    else $error("clock configuration readback wrong");
  a_ea_wraps: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL2]
    (instr_valid && is_d) |=> dec_ea == 32'($past(reg_a_val) + $past(disp)))
    else $error("effective address wrong");
  a_sia_capture: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL11]
    (nxt_pmi && !pmi_ff) |=> samp_ff == $past(exec_addr))
    else $error("sampled address not captured");
  a_no_compute_store: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL3]
    (instr_valid && op == OP_ADDI) |=> !dec_mem_write)
    else $error("computation wrote memory");
  a_misaligned_fetch: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL1]
    (instr_valid && instr_addr[1:0] != 2'h0) |=> dec_illegal)
    else $error("unaligned fetch accepted");
  a_thermal_off: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL14]
    !thrc_ff[THRM_EN_BIT] |=> !thermal_alert)
    else $error("alert while thermal unit off");
  a_alias_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL9]
    (instr_valid && is_mf && problem_state_bit && spr == SPR_U_SAMP)
    |=> spr_rd_data == $past(samp_ff))
    else $error("user alias read failed");

endmodule : instr_decode
`default_nettype wire

/* File: core/idec_pkg.sv */
// Package with constants for the instruction decode and special-register block.
package idec_pkg;

  localparam int WORD_W = 32;
  localparam int REG_IDX_W = 5;
  localparam int SPR_W = 10;

  // Primary opcodes and extended opcodes, in the architectural encoding.
  localparam logic [5:0] OP_EXT31 = 6'h1F;
  localparam logic [5:0] OP_EXT59 = 6'h3B;
  localparam logic [5:0] OP_EXT63 = 6'h3F;
  localparam logic [5:0] OP_LWZ = 6'h20;
  localparam logic [5:0] OP_LBZ = 6'h22;
  localparam logic [5:0] OP_STW = 6'h24;
  localparam logic [5:0] OP_STB = 6'h26;
  localparam logic [5:0] OP_LHZ = 6'h28;
  localparam logic [5:0] OP_LHA = 6'h2A;
  localparam logic [5:0] OP_STH = 6'h2C;
  localparam logic [5:0] OP_LFS = 6'h30;
  localparam logic [5:0] OP_LFD = 6'h32;
  localparam logic [5:0] OP_STFS = 6'h34;
  localparam logic [5:0] OP_STFD = 6'h36;
  localparam logic [5:0] OP_ADDI = 6'h0E;
  localparam logic [9:0] XO_MFSPR = 10'h153;
  localparam logic [9:0] XO_MTSPR = 10'h1D3;
  localparam logic [9:0] XO_ECIWX = 10'h136;
  localparam logic [9:0] XO_ECOWX = 10'h1B6;
  localparam logic [9:0] XO_STFIWX = 10'h3D7;
  localparam logic [4:0] XO_FSEL = 5'h17;
  localparam logic [4:0] XO_FRES = 5'h18;
  localparam logic [4:0] XO_FRSQRTE = 5'h1A;

  // Special register numbers.
  localparam logic [9:0] SPR_U_MON_A = 10'h3A8;
  localparam logic [9:0] SPR_U_CNT1 = 10'h3A9;
  localparam logic [9:0] SPR_U_CNT2 = 10'h3AA;
  localparam logic [9:0] SPR_U_SAMP = 10'h3AB;
  localparam logic [9:0] SPR_U_MON_B = 10'h3AC;
  localparam logic [9:0] SPR_U_CNT3 = 10'h3AD;
  localparam logic [9:0] SPR_U_CNT4 = 10'h3AE;
  localparam logic [9:0] SPR_MON_A = 10'h3B8;
  localparam logic [9:0] SPR_CNT1 = 10'h3B9;
  localparam logic [9:0] SPR_CNT2 = 10'h3BA;
  localparam logic [9:0] SPR_SAMP = 10'h3BB;
  localparam logic [9:0] SPR_MON_B = 10'h3BC;
  localparam logic [9:0] SPR_CNT3 = 10'h3BD;
  localparam logic [9:0] SPR_CNT4 = 10'h3BE;
  localparam logic [9:0] SPR_THRMA = 10'h3FC;
  localparam logic [9:0] SPR_THRMB = 10'h3FD;
  localparam logic [9:0] SPR_THRMC = 10'h3FE;
  localparam logic [9:0] SPR_THROT = 10'h3FB;
  localparam logic [9:0] SPR_IMPL0 = 10'h3F0;
  localparam logic [9:0] SPR_IMPL1 = 10'h3F1;
  localparam logic [9:0] SPR_BKPT = 10'h3F2;

  // Field positions inside the owned registers.
  localparam int BKPT_EN_BIT = 0;
  localparam int THROT_EN_BIT = 0;
  localparam int THROT_INT_LSB = 1;
  localparam int THROT_INT_W = 8;
  localparam int THR_VALID_BIT = 0;
  localparam int THR_DIR_BIT = 1;
  localparam int THR_LSB = 24;
  localparam int THR_W = 7;
  localparam int THRM_EN_BIT = 0;
  localparam int THRM_SIT_LSB = 1;
  localparam int THRM_SIT_W = 13;
  localparam int MMCR_EV_W = 7;
  localparam int MMCR_PMI_BIT = 31;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE} size_type;
  typedef enum logic [1:0] {FILE_NONE, FILE_INT, FILE_FLT} file_type;

endpackage : idec_pkg

/* File: core/perf_counters.sv */
// Four event counters with selectable events and an overflow flag.
`timescale 1ns/1ps
`default_nettype none
module perf_counters
  import idec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [31:0] ctrl_a,
  input wire logic [31:0] ctrl_b,
  input wire logic [WORD_W-1:0] event_vec,
  input wire logic load_en,
  input wire logic [1:0] load_idx,
  input wire logic [31:0] load_val,
  output logic [127:0] counts,
  output logic overflow
);

  logic [31:0] cnt_ff [4];
  logic [31:0] nxt_cnt [4];
  logic [6:0] sel [4];

  ////////////////////////////////////////////////////////////////////////////
  assign sel[0] = ctrl_a[MMCR_EV_W-1:0];
  assign sel[1] = ctrl_a[2*MMCR_EV_W-1:MMCR_EV_W];
  assign sel[2] = ctrl_b[MMCR_EV_W-1:0];
  assign sel[3] = ctrl_b[2*MMCR_EV_W-1:MMCR_EV_W];

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      nxt_cnt[i] = cnt_ff[i];
      if (load_en && load_idx == 2'(i))
      begin
        nxt_cnt[i] = load_val;
      end
      else if (sel[i] != 7'h00 && event_vec[sel[i][4:0]])
      begin
        nxt_cnt[i] = cnt_ff[i] + 32'h0000_0001; // [RL10]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        cnt_ff[i] <= RESET_WORD;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // The top bit of a counter going high is the monitor condition.
  assign counts = {cnt_ff[3], cnt_ff[2], cnt_ff[1], cnt_ff[0]};
  assign overflow = cnt_ff[0][31] | cnt_ff[1][31] | cnt_ff[2][31] | cnt_ff[3][31];

endmodule : perf_counters
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the instruction decode and special register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import idec_pkg::*;
  logic sys_clk, resetn, instr_valid, problem_state_bit;
  logic [31:0] instr_word, instr_addr, reg_a_val, reg_b_val, spr_wr_data, perf_events, exec_addr;
  logic [3:0] pll_cfg;
  logic [6:0] thermal_sensor;
  logic dec_valid, dec_illegal, dec_privileged, dec_mem_write, dec_mem_read;
  logic breakpoint_trap, fetch_enable, thermal_alert, perf_interrupt;
  logic [1:0] dec_size, dec_file;
  logic [4:0] dec_rt;
  logic [31:0] dec_ea, spr_rd_data, seed, ra, bp, val;
  logic [15:0] d;
  logic [31:0] shadow [logic [9:0]];
  int err_total, num_checks, cnt;
  logic [5:0] lsop [11] = '{OP_LWZ, OP_LBZ, OP_LHZ, OP_LHA, OP_STW, OP_STB, OP_STH, OP_LFS,
    OP_LFD, OP_STFS, OP_STFD};
  // Expected {write, size, file} for each entry of the load and store table.
  logic [4:0] lsexp [11] = '{5'b0_10_01, 5'b0_00_01, 5'b0_01_01, 5'b0_01_01, 5'b1_10_01,
    5'b1_00_01, 5'b1_01_01, 5'b0_10_10, 5'b0_11_10, 5'b1_10_10, 5'b1_11_10};
  logic [31:0] optw [6];

  instr_decode i_instr_decode (.sys_clk, .resetn, .instr_valid, .instr_word, .instr_addr,
    .reg_a_val, .reg_b_val, .spr_wr_data, .problem_state_bit, .pll_cfg, .thermal_sensor,
    .perf_events, .exec_addr, .dec_valid, .dec_illegal, .dec_privileged, .dec_mem_write,
    .dec_mem_read, .dec_size, .dec_file, .dec_rt, .dec_ea, .spr_rd_data, .breakpoint_trap,
    .fetch_enable, .thermal_alert, .perf_interrupt);

  ////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] sx(input logic [9:0] xo, input logic [9:0] n);
    return {OP_EXT31, 5'h2, n[4:0], n[9:5], xo, 1'b0};
  endfunction : sx

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // Drives one instruction after a falling edge; its results are settled at the next one.
  task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic usr);
    @(negedge sys_clk);
    instr_word = w;
    instr_addr = a;
    problem_state_bit = usr;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
  endtask : issue

  task automatic mt(input logic [9:0] n, input logic [31:0] v, input logic usr);
    spr_wr_data = v;
    issue(sx(XO_MTSPR, n), 32'h0000_0100, usr);
    chk("mtspr privileged", {31'h0, dec_privileged}, {31'h0, usr});
    if (!usr)
      shadow[n] = v;
  endtask : mt

  task automatic rd(input logic [9:0] n, input logic usr, input logic [31:0] exp);
    issue(sx(XO_MFSPR, n), 32'h0000_0104, usr);
    chk("mfspr data", spr_rd_data, exp);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50us;
    err_total++;
    close_out();
  end

  initial
  begin
    seed = 32'h0000_00ed;
    resetn = 1'b0;
    {instr_valid, problem_state_bit} = 2'b00;
    {instr_word, instr_addr, reg_a_val, reg_b_val, spr_wr_data, perf_events} = '0;
    exec_addr = rnd() & 32'hFFFF_FFFC;
    pll_cfg = 4'(rnd());
    thermal_sensor = 7'h00;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    chk("size at reset", {30'h0, dec_size}, 32'h0000_0002);
    chk("fetch at reset", {31'h0, fetch_enable}, 32'h0000_0001);
    chk("valid at reset", {31'h0, dec_valid}, 32'h0000_0000);
    // The first entry forces a wrap so that a dropped carry is seen.
    for (int i = 0; i < 11; i++)
    begin
      ra = (i == 0) ? 32'hFFFF_FFF0 : rnd();
      d = (i == 0) ? 16'h0020 : 16'(rnd());
      reg_a_val = ra;
      reg_b_val = rnd();
      issue({lsop[i], 5'(i + 4), 5'h3, d}, 32'h0000_0200, 1'b0);
      chk("valid", {31'h0, dec_valid}, 32'h0000_0001);
      chk("ea", dec_ea, ra + {{16{d[15]}}, d});
      chk("write", {31'h0, dec_mem_write}, {31'h0, lsexp[i][4]});
      chk("read", {31'h0, dec_mem_read}, {31'h0, ~lsexp[i][4]});
      chk("size", {30'h0, dec_size}, {30'h0, lsexp[i][3:2]});
      chk("file", {30'h0, dec_file}, {30'h0, lsexp[i][1:0]});
      chk("target", {27'h0, dec_rt}, 32'(i + 4));
    end
    issue({OP_ADDI, 5'h1, 5'h3, 16'h0040}, 32'h0000_0300, 1'b0);
    chk("addi write", {31'h0, dec_mem_write}, 32'h0000_0000);
    optw = '{sx(XO_ECIWX, 10'h0), sx(XO_ECOWX, 10'h0), sx(XO_STFIWX, 10'h0),
      {OP_EXT63, 15'h0443, 5'h4, XO_FSEL, 1'b0}, {OP_EXT59, 15'h0043, 5'h0, XO_FRES, 1'b0},
      {OP_EXT63, 15'h0043, 5'h0, XO_FRSQRTE, 1'b0}};
    foreach (optw[i])
    begin
      issue(optw[i], 32'h0000_0400, 1'b0);
      chk("optional accepted", {31'h0, dec_illegal}, 32'h0000_0000);
      chk("optional store", {31'h0, dec_mem_write}, {31'h0, i == 1 || i == 2});
      if (i < 3)
        chk("indexed ea", dec_ea, reg_a_val + reg_b_val);
    end
    issue(32'h0000_0000, 32'h0000_0500, 1'b0);
    chk("opcode zero", {31'h0, dec_illegal}, 32'h0000_0001);
    issue({OP_ADDI, 26'h0}, 32'h0000_0502, 1'b0);
    chk("misaligned", {31'h0, dec_illegal}, 32'h0000_0001);
    rd(SPR_IMPL1, 1'b0, {28'h0, pll_cfg});
    rd(SPR_IMPL1, 1'b1, 32'h0000_0000);
    chk("user impl read", {31'h0, dec_privileged}, 32'h0000_0001);
    // A user move to a register outside this block is an ordinary instruction.
    issue(sx(XO_MTSPR, 10'h008), 32'h0000_0100, 1'b1);
    chk("user other spr", {31'h0, dec_privileged}, 32'h0000_0000);
    // Breakpoint address, then a user write that must be refused.
    bp = rnd() & 32'hFFFF_FFFC;
    mt(SPR_BKPT, bp | 32'h0000_0001, 1'b0);
    mt(SPR_BKPT, 32'h0000_0000, 1'b1);
    rd(SPR_BKPT, 1'b0, shadow[SPR_BKPT]);
    issue({OP_ADDI, 26'h0}, bp, 1'b0);
    chk("breakpoint hit", {31'h0, breakpoint_trap}, 32'h0000_0001);
    issue({OP_ADDI, 26'h0}, bp + 32'h0000_0004, 1'b0);
    chk("breakpoint miss", {31'h0, breakpoint_trap}, 32'h0000_0000);
    // Counter one selects event one, with the monitor interrupt enabled.
    mt(SPR_MON_A, 32'h8000_0001, 1'b0);
    mt(SPR_CNT1, 32'h7FFF_FFFE, 1'b0);
    mt(SPR_U_MON_A, 32'h0000_0000, 1'b1);
    rd(SPR_U_MON_A, 1'b1, shadow[SPR_MON_A]);
    chk("alias read", {31'h0, dec_privileged}, 32'h0000_0000);
    chk("no interrupt yet", {31'h0, perf_interrupt}, 32'h0000_0000);
    @(negedge sys_clk);
    perf_events = 32'h0000_0002;
    repeat (2) @(negedge sys_clk);
    perf_events = 32'h0000_0000;
    repeat (3) @(negedge sys_clk);
    chk("monitor interrupt", {31'h0, perf_interrupt}, 32'h0000_0001);
    rd(SPR_U_CNT1, 1'b1, 32'h8000_0000);
    rd(SPR_U_SAMP, 1'b1, exec_addr);
    // An interval of two gives one fetch slot in every three cycles.
    mt(SPR_THROT, 32'h0000_0005, 1'b0);
    repeat (4) @(negedge sys_clk);
    cnt = 0;
    repeat (30)
    begin
      @(negedge sys_clk);
      cnt += (fetch_enable === 1'b1);
    end
    chk("fetch slots", 32'(cnt), 32'd10);
    mt(SPR_THROT, 32'h0000_0000, 1'b0);
    chk("alert idle", {31'h0, thermal_alert}, 32'h0000_0000);
    thermal_sensor = 7'h30;
    mt(SPR_THRMA, 32'h2000_0003, 1'b0);
    mt(SPR_THRMC, 32'h0000_0003, 1'b0);
    cnt = 0;
    while (thermal_alert !== 1'b1 && cnt < 200)
    begin
      @(negedge sys_clk);
      cnt++;
    end
    chk("alert above", {31'h0, thermal_alert}, 32'h0000_0001);
    close_out();
  end
endmodule : tb
`default_nettype wire
